// [rtl/fpdc_pkg.sv]
// Package of constants for the fractional PLL DCO control block.
package fpdc_pkg;
  // Register offsets (byte address on the plain register port).
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_REFCFG = 8'h04;
  localparam logic [7:0] ADDR_PLLCFG = 8'h08;
  localparam logic [7:0] ADDR_FBINT = 8'h0c;
  localparam logic [7:0] ADDR_FBFRAC = 8'h10;
  localparam logic [7:0] ADDR_FREQ = 8'h14;
  localparam logic [7:0] ADDR_TRIM = 8'h18;
  localparam logic [7:0] ADDR_APPLY = 8'h1c;
  localparam logic [7:0] ADDR_MODE = 8'h20;
  // Status register bit positions.
  localparam int ST_CAL_DONE = 0;
  localparam int ST_CAL_FAIL = 1;
  localparam int ST_LOCK = 2;
  localparam int ST_LOL = 3;
  localparam int ST_SEQ_DONE = 4;
  localparam int ST_PEND = 5;
  // Reference configuration bit positions.
  localparam int RC_CMOS_SEL = 0;
  localparam int RC_BIAS = 1;
  localparam int RC_INBUF = 2;
  localparam int RC_RANGE = 4;
  localparam int RC_RANGE_W = 2;
  // PLL configuration bit positions.
  localparam int PC_DOUBLER = 0;
  localparam int PC_REF_SEL = 1;
  localparam int PC_BYPASS = 2;
  localparam int PC_GPO_LOCK = 3;
  // Reset values.
  localparam logic [31:0] REFCFG_RST = 32'h0000_0000;
  localparam logic [31:0] PLLCFG_RST = 32'h0000_0000;
  localparam logic [31:0] FBINT_RST = 32'h0000_0064;
  localparam logic [31:0] FBFRAC_RST = 32'h0000_0000;
  // Field widths.
  localparam int FRAC_W = 27;
  localparam int INT_W = 10;
  localparam int OFFS_W = 32;
  localparam int OFFS_LSB_EXP = 40;
  // Startup sequence timing, in ns, and derived cycles at 25 MHz.
  localparam int CLK_PERIOD_NS = 40;
  localparam int REG_SETTLE_NS = 2000;
  localparam int REG_SETTLE_CYC = (REG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAGE_NS = 400;
  localparam int STAGE_CYC = (STAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Operating modes.
  typedef enum logic [1:0] {
    FPDC_MODE_SYNTH = 2'b00,
    FPDC_MODE_DCO = 2'b01,
    FPDC_MODE_CLKGEN = 2'b10
  } fpdc_mode_t;
  // Startup sequence states.
  typedef enum logic [2:0] {
    FPDC_SEQ_HOLD = 3'b000,
    FPDC_SEQ_BIAS = 3'b001,
    FPDC_SEQ_CAL = 3'b010,
    FPDC_SEQ_PLL = 3'b011,
    FPDC_SEQ_RUN = 3'b100
  } fpdc_seq_t;
endpackage

// [rtl/fpdc_top.sv]
// Digital control and status logic around a fractional-feedback PLL.
//
// Behaviour
// - Hold logic in reset, then release in sequence.
// - Bias calibration sets done or fail, continues.
// - One bit selects differential or single-ended reference.
// - Reference pad disabled after reset until enabled.
// - Doubler bit doubles reference before detector.
// - Select bit picks crystal or differential reference.
// - Ratio is integer plus 27-bit fraction.
// - Sigma-delta switches divider ratios, noise shaped.
// - Lock state readable and routable to output.
// - Lock falling edge sets sticky loss event.
// - DCO word scaled by ratio, applied to divider.
// - Offset word LSB weight two to minus forty.
// - Fixed crystal trim added to control word.
// - Synthesizer and DCO run from crystal or input.
// - Clock generator locks to differential input.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module fpdc_top
  import fpdc_pkg::*;
#(
  parameter int SETTLE_CYC = REG_SETTLE_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Analog status inputs.
  input wire logic regulators_ok,
  input wire logic bias_cal_ready,
  input wire logic bias_cal_error,
  input wire logic pll_lock_raw,
  input wire logic feedback_tick,
  // Analog control outputs.
  output logic block_reset_n_ff,
  output logic pll_reset_n_ff,
  output logic bias_cal_start,
  output logic ref_cmos_select,
  output logic ac_coupled_bias_enable,
  output logic ref_input_enable,
  output logic doubler_enable,
  output logic ref_from_clkin,
  output logic third_pole_bypass,
  output logic [1:0] lock_range_sel,
  output logic [INT_W-1:0] divider_ratio_ff,
  output logic gpo_lock
);

  // Control registers written by software.
  logic [31:0] refcfg_ff;
  logic [31:0] pllcfg_ff;
  logic [INT_W-1:0] fbint_ff;
  logic [FRAC_W-1:0] fbfrac_ff;
  logic [OFFS_W-1:0] freq_ff;
  logic [OFFS_W-1:0] trim_ff;
  fpdc_mode_t mode_ff;
  // Pending update request and the active copies used by the modulator.
  logic pend_ff;
  logic [INT_W-1:0] act_int_ff;
  logic [FRAC_W-1:0] act_frac_ff;
  // Startup sequencer state and counter.
  fpdc_seq_t seq_ff;
  fpdc_seq_t nxt_seq;
  logic [15:0] cnt_ff;
  logic cal_done_ff;
  logic cal_fail_ff;
  // Lock tracking and sticky loss event.
  logic lock_ff;
  logic lol_ff;
  // Modulator accumulators, second order error feedback.
  logic [FRAC_W:0] acc1_ff;
  logic [FRAC_W:0] acc2_ff;

  // Write decode wires.
  wire wr_refcfg = reg_wr && (reg_addr == ADDR_REFCFG);
  wire wr_pllcfg = reg_wr && (reg_addr == ADDR_PLLCFG);
  wire wr_fbint = reg_wr && (reg_addr == ADDR_FBINT);
  wire wr_fbfrac = reg_wr && (reg_addr == ADDR_FBFRAC);
  wire wr_freq = reg_wr && (reg_addr == ADDR_FREQ);
  wire wr_trim = reg_wr && (reg_addr == ADDR_TRIM);
  wire wr_apply = reg_wr && (reg_addr == ADDR_APPLY);
  wire wr_mode = reg_wr && (reg_addr == ADDR_MODE);
  wire wr_status = reg_wr && (reg_addr == ADDR_STATUS);
  wire running = (seq_ff == FPDC_SEQ_RUN);

  // Combined offset: control word only counts in DCO mode, trim always.
  wire signed [OFFS_W:0] offs_sum = (mode_ff == FPDC_MODE_DCO) ?
      ($signed({freq_ff[OFFS_W-1], freq_ff}) + $signed({trim_ff[OFFS_W-1], trim_ff})) :
      $signed({trim_ff[OFFS_W-1], trim_ff});
  // Nominal ratio as fixed point with a 27-bit fraction.
  wire [INT_W+FRAC_W-1:0] nom_ratio = {fbint_ff, fbfrac_ff};
  // Ratio times offset, scaled by 2^-40 for the offset LSB weight.
  localparam int PROD_W = INT_W + FRAC_W + OFFS_W + 2;
  wire signed [PROD_W-1:0] delta_full =
      PROD_W'($signed({1'b0, nom_ratio})) * PROD_W'(offs_sum);
  wire signed [INT_W+FRAC_W+1:0] delta =
      delta_full[INT_W+FRAC_W+OFFS_W+1 -: INT_W+FRAC_W+2] >>> 0;
  // The top slice drops OFFS_W bits; the rest of the offset weight is shifted here.
  wire [INT_W+FRAC_W+1:0] adj_ratio =
      $unsigned($signed({2'b00, nom_ratio}) + (delta >>> (OFFS_LSB_EXP - OFFS_W)));
  wire [INT_W-1:0] new_int = adj_ratio[INT_W+FRAC_W-1:FRAC_W];
  wire [FRAC_W-1:0] new_frac = adj_ratio[FRAC_W-1:0];

  // Modulator stage sums; carries pick the divider step.
  wire [FRAC_W:0] sum1 = {1'b0, acc1_ff[FRAC_W-1:0]} + {1'b0, act_frac_ff};
  wire [FRAC_W:0] sum2 = {1'b0, acc2_ff[FRAC_W-1:0]} + {1'b0, sum1[FRAC_W-1:0]};
  wire c1 = sum1[FRAC_W];
  wire c2 = sum2[FRAC_W];
  wire c2_prev = acc2_ff[FRAC_W];
  // Noise-shaped step: c1 + c2 - c2 of the previous tick.
  // Steps range from minus one to plus two around the integer part.
  wire signed [2:0] sdm_step = $signed({2'b00, c1}) + $signed({2'b00, c2})
      - $signed({2'b00, c2_prev});

  // Reference path and analog control follow configuration, with the
  // input pad gated off until software enables it.
  assign ref_cmos_select = refcfg_ff[RC_CMOS_SEL];
  assign ac_coupled_bias_enable = refcfg_ff[RC_BIAS];
  assign ref_input_enable = refcfg_ff[RC_INBUF] || (mode_ff == FPDC_MODE_CLKGEN);
  assign lock_range_sel = refcfg_ff[RC_RANGE +: RC_RANGE_W];
  assign doubler_enable = pllcfg_ff[PC_DOUBLER];
  // Clock generator mode always locks to the differential input.
  assign ref_from_clkin = (mode_ff == FPDC_MODE_CLKGEN) ? 1'b1 : pllcfg_ff[PC_REF_SEL];
  // Bypass only passes while the active fraction is zero.
  assign third_pole_bypass = pllcfg_ff[PC_BYPASS] && (act_frac_ff == '0);
  assign gpo_lock = pllcfg_ff[PC_GPO_LOCK] ? lock_ff : 1'b0;
  assign bias_cal_start = (seq_ff == FPDC_SEQ_CAL);

  // Startup sequencer next-state logic.
  always_comb begin
    nxt_seq = seq_ff;
    unique case (seq_ff)
      FPDC_SEQ_HOLD: if (regulators_ok && cnt_ff >= 16'(SETTLE_CYC)) nxt_seq = FPDC_SEQ_BIAS;
      FPDC_SEQ_BIAS: if (cnt_ff >= 16'(STAGE_CYC)) nxt_seq = FPDC_SEQ_CAL;
      FPDC_SEQ_CAL: if (bias_cal_ready || bias_cal_error) nxt_seq = FPDC_SEQ_PLL;
      FPDC_SEQ_PLL: if (cnt_ff >= 16'(STAGE_CYC)) nxt_seq = FPDC_SEQ_RUN;
      FPDC_SEQ_RUN: nxt_seq = FPDC_SEQ_RUN;
      default: nxt_seq = FPDC_SEQ_HOLD;
    endcase
  end

  // Sequencer registers; the counter restarts on each state change.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      seq_ff <= FPDC_SEQ_HOLD;
      cnt_ff <= 16'h0000;
      block_reset_n_ff <= 1'b0;
      pll_reset_n_ff <= 1'b0;
      cal_done_ff <= 1'b0;
      cal_fail_ff <= 1'b0;
    end else begin
      seq_ff <= nxt_seq;
      cnt_ff <= (nxt_seq != seq_ff) ? 16'h0000 :
          ((seq_ff == FPDC_SEQ_HOLD && !regulators_ok) ? 16'h0000 : cnt_ff + 16'h0001);
      block_reset_n_ff <= (nxt_seq != FPDC_SEQ_HOLD);
      pll_reset_n_ff <= (nxt_seq == FPDC_SEQ_RUN);
      if (seq_ff == FPDC_SEQ_CAL && bias_cal_error) begin
        cal_fail_ff <= 1'b1;
      end else if (seq_ff == FPDC_SEQ_CAL && bias_cal_ready) begin
        cal_done_ff <= 1'b1;
      end
    end
  end

  // Software-written configuration registers.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      refcfg_ff <= REFCFG_RST;
      pllcfg_ff <= PLLCFG_RST;
      fbint_ff <= FBINT_RST[INT_W-1:0];
      fbfrac_ff <= FBFRAC_RST[FRAC_W-1:0];
      freq_ff <= '0;
      trim_ff <= '0;
      mode_ff <= FPDC_MODE_SYNTH;
    end else begin
      if (wr_refcfg) refcfg_ff <= reg_wdata;
      if (wr_pllcfg) pllcfg_ff <= reg_wdata;
      if (wr_fbint) fbint_ff <= reg_wdata[INT_W-1:0];
      if (wr_fbfrac) fbfrac_ff <= reg_wdata[FRAC_W-1:0];
      if (wr_freq) freq_ff <= reg_wdata;
      if (wr_trim) trim_ff <= reg_wdata;
      if (wr_mode) mode_ff <= (reg_wdata[1:0] == 2'b11) ? FPDC_MODE_SYNTH :
          fpdc_mode_t'(reg_wdata[1:0]);
    end
  end

  // Atomic transfer of new words at a feedback tick, after an apply.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pend_ff <= 1'b0;
      act_int_ff <= FBINT_RST[INT_W-1:0];
      act_frac_ff <= FBFRAC_RST[FRAC_W-1:0];
    end else begin
      if (pend_ff && feedback_tick) begin
        act_int_ff <= new_int;
        act_frac_ff <= new_frac;
        // A request that lands on the tick itself stays pending for the next one.
        pend_ff <= wr_apply || wr_freq;
      end else if (wr_apply || wr_freq) begin
        pend_ff <= 1'b1;
      end
    end
  end

  // Modulator and divider ratio, stepped once per feedback tick.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      acc1_ff <= '0;
      acc2_ff <= '0;
      divider_ratio_ff <= FBINT_RST[INT_W-1:0];
    end else if (feedback_tick && running) begin
      acc1_ff <= sum1;
      acc2_ff <= sum2;
      divider_ratio_ff <= act_int_ff + INT_W'(sdm_step);
    end
  end

  // Lock tracking and the sticky loss-of-lock event; set wins on clear.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lock_ff <= 1'b0;
      lol_ff <= 1'b0;
    end else begin
      lock_ff <= pll_lock_raw && running;
      if (lock_ff && !(pll_lock_raw && running)) begin
        lol_ff <= 1'b1;
      end else if (wr_status && reg_wdata[ST_LOL]) begin
        lol_ff <= 1'b0;
      end
    end
  end

  // Read data, valid in the cycle after the read strobe only.
  always_ff @(posedge clk) begin
    if (!reset_n || !reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      unique case (reg_addr)
        ADDR_STATUS: reg_rdata <= {26'h0, pend_ff, running, lol_ff, lock_ff,
            cal_fail_ff, cal_done_ff};
        ADDR_REFCFG: reg_rdata <= refcfg_ff;
        ADDR_PLLCFG: reg_rdata <= pllcfg_ff;
        ADDR_FBINT: reg_rdata <= 32'(act_int_ff);
        ADDR_FBFRAC: reg_rdata <= 32'(act_frac_ff);
        ADDR_FREQ: reg_rdata <= freq_ff;
        ADDR_TRIM: reg_rdata <= trim_ff;
        ADDR_MODE: reg_rdata <= 32'(mode_ff);
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // Lock loss must raise the sticky event in the same cycle that lock reads low.
  sequence lock_drop_s;
    lock_ff ##1 !lock_ff;
  endsequence
  lol_set_a: assert property (@(posedge clk) disable iff (!reset_n)
      lock_drop_s |-> lol_ff) else $error("Loss event not set after lock drop");
  // Clear with no drop takes effect.
  lol_clr_a: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_status && reg_wdata[ST_LOL] && !(lock_ff && !(pll_lock_raw && running)))
      |=> !lol_ff) else $error("Loss event clear failed");
  // Release order: blocks out of reset before the PLL.
  rst_order_a: assert property (@(posedge clk) disable iff (!reset_n)
      pll_reset_n_ff |-> block_reset_n_ff) else $error("PLL released before blocks");
  // A calibration failure is latched and the sequence moves on.
  cal_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
      (seq_ff == FPDC_SEQ_CAL && bias_cal_error) |=> cal_fail_ff && seq_ff == FPDC_SEQ_PLL)
      else $error("Calibration failure not recorded");
  // The reference pad stays off until software enables it.
  pad_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      (!refcfg_ff[RC_INBUF] && mode_ff != FPDC_MODE_CLKGEN) |-> !ref_input_enable)
      else $error("Reference pad on without enable");
  // Clock generator mode always takes the differential input.
  clkgen_ref_a: assert property (@(posedge clk) disable iff (!reset_n)
      (mode_ff == FPDC_MODE_CLKGEN) |-> ref_from_clkin) else $error("Clock gen not on input");
  // The active fraction only changes on a pending tick.
  atomic_upd_a: assert property (@(posedge clk) disable iff (!reset_n)
      (!$past(pend_ff) || !$past(feedback_tick)) |-> $stable(act_frac_ff))
      else $error("Fraction changed off boundary");
  // The output pin mirrors lock when routed there.
  gpo_lock_a: assert property (@(posedge clk) disable iff (!reset_n)
      pllcfg_ff[PC_GPO_LOCK] |-> (gpo_lock == lock_ff)) else $error("GPO not showing lock");
  // The divider never steps below one under the integer part.
  step_range_a: assert property (@(posedge clk) disable iff (!reset_n)
      (feedback_tick && running) |=> (divider_ratio_ff >= $past(act_int_ff) - INT_W'(1)))
      else $error("Divider step out of range");
  // Further checks on sequencing, events, the modulator, reference select and bypass.
  // The PLL leaves reset only once the sequencer has reached its run state.
  pll_run_a: assert property (@(posedge clk) disable iff (!reset_n)
      pll_reset_n_ff |-> running) else $error("PLL released before run state");
  // While the sequencer holds, every block stays in reset.
  hold_rst_a: assert property (@(posedge clk) disable iff (!reset_n)
      (seq_ff == FPDC_SEQ_HOLD) |-> (!block_reset_n_ff && !pll_reset_n_ff))
      else $error("Blocks released during hold");
  // Calibration ends on either outcome.
  sequence cal_end_s;
    (seq_ff == FPDC_SEQ_CAL) && (bias_cal_ready || bias_cal_error);
  endsequence
  // The stage that follows calibration, whatever the outcome.
  sequence pll_stage_s;
    seq_ff == FPDC_SEQ_PLL;
  endsequence
  cal_next_a: assert property (@(posedge clk) disable iff (!reset_n)
      cal_end_s |=> pll_stage_s) else $error("Sequence stalled after calibration");
  cal_done_a: assert property (@(posedge clk) disable iff (!reset_n)
      ((seq_ff == FPDC_SEQ_CAL) && bias_cal_ready && !bias_cal_error) |=> cal_done_ff)
      else $error("Calibration completion not recorded");
  // The sticky event stays set until a clear that meets no new drop.
  lol_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      (lol_ff && !(wr_status && reg_wdata[ST_LOL])) |=> lol_ff)
      else $error("Loss event dropped without clear");
  // A running loop with the detector high shows lock one cycle later.
  lock_seen_a: assert property (@(posedge clk) disable iff (!reset_n)
      (pll_lock_raw && running) |=> lock_ff) else $error("Lock not tracked");
  // Every apply or offset write leaves an update pending.
  pend_set_a: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_apply || wr_freq) |=> pend_ff) else $error("Update request lost");
  // The divider ratio only moves on a feedback tick.
  ratio_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      !(feedback_tick && running) |=> $stable(divider_ratio_ff))
      else $error("Divider moved between ticks");
  // Outside clock generator mode, the select bit alone picks the reference.
  ref_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
      (mode_ff != FPDC_MODE_CLKGEN) |-> (ref_from_clkin == pllcfg_ff[PC_REF_SEL]))
      else $error("Reference select not followed");
  // Bypass never passes while a fractional ratio is active.
  bypass_int_a: assert property (@(posedge clk) disable iff (!reset_n)
      third_pole_bypass |-> (act_frac_ff == '0)) else $error("Bypass on with fraction");

endmodule // fpdc_top

// [bench/fpdc_analog_model.sv]
// Behavioural model of the analog loop, its feedback divider and the bias calibrator.
`timescale 1ns/1ps
module fpdc_analog_model (
  // Clock and controls from the block.
  input wire logic clk,
  input wire logic pll_reset_n,
  input wire logic bias_cal_start,
  // Controls from the bench.
  input wire logic cal_err_mode,
  input wire logic lock_on,
  input wire logic tick_en,
  // Status towards the block.
  output logic bias_cal_ready,
  output logic bias_cal_error,
  output logic pll_lock_raw,
  output logic feedback_tick
);
  logic [1:0] div_ff; // Feedback divider phase.
  logic [2:0] cal_ff; // Calibration run time.
  // The loop ticks every fourth cycle out of reset; tick_en lets the bench stall it.
  always_ff @(posedge clk) begin
    div_ff <= pll_reset_n ? div_ff + {1'b0, tick_en} : 2'h0;
    cal_ff <= bias_cal_start ? cal_ff + {2'h0, cal_ff != 3'h7} : 3'h0;
  end
  assign feedback_tick = pll_reset_n & tick_en & (div_ff == 2'h3);
  // Calibration answers a few cycles after start, with the outcome the bench asks for.
  assign bias_cal_ready = (cal_ff > 3'h3) & ~cal_err_mode;
  assign bias_cal_error = (cal_ff > 3'h3) & cal_err_mode;
  assign pll_lock_raw = lock_on & pll_reset_n;
endmodule // fpdc_analog_model

// [bench/fractional_pll_dco_control_test.sv]
// Self-checking bench for the fractional PLL DCO control block.
`timescale 1ns/1ps
module fractional_pll_dco_control_test;
  import fpdc_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic regulators_ok = 1'b0;
  logic cal_err_mode = 1'b0;
  logic lock_on = 1'b0;
  logic tick_en = 1'b1;
  logic [31:0] reg_rdata, rd_v, seed = 32'h0000_0bc4;
  logic block_reset_n_ff, pll_reset_n_ff, bias_cal_start, ref_cmos_select, gpo_lock;
  logic ac_coupled_bias_enable, ref_input_enable, doubler_enable, ref_from_clkin;
  logic third_pole_bypass, bias_cal_ready, bias_cal_error, pll_lock_raw, feedback_tick;
  logic [1:0] lock_range_sel;
  logic [INT_W-1:0] divider_ratio_ff;
  int failures = 0;
  int compares = 0;
  longint acc;
  // Free running 25 MHz clock.
  always #20 clk = ~clk;
  fpdc_top #(.SETTLE_CYC(4)) uut (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .regulators_ok(regulators_ok),
    .bias_cal_ready(bias_cal_ready), .bias_cal_error(bias_cal_error),
    .pll_lock_raw(pll_lock_raw), .feedback_tick(feedback_tick),
    .block_reset_n_ff(block_reset_n_ff), .pll_reset_n_ff(pll_reset_n_ff),
    .bias_cal_start(bias_cal_start), .ref_cmos_select(ref_cmos_select),
    .ac_coupled_bias_enable(ac_coupled_bias_enable), .ref_input_enable(ref_input_enable),
    .doubler_enable(doubler_enable), .ref_from_clkin(ref_from_clkin),
    .third_pole_bypass(third_pole_bypass), .lock_range_sel(lock_range_sel),
    .divider_ratio_ff(divider_ratio_ff), .gpo_lock(gpo_lock));
  fpdc_analog_model ana (
    .clk(clk), .pll_reset_n(pll_reset_n_ff), .bias_cal_start(bias_cal_start),
    .cal_err_mode(cal_err_mode), .lock_on(lock_on), .tick_en(tick_en),
    .bias_cal_ready(bias_cal_ready), .bias_cal_error(bias_cal_error),
    .pll_lock_raw(pll_lock_raw), .feedback_tick(feedback_tick));
  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Exact comparison of a register or pin value.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Comparison of an averaged divider sum, within the modulator's noise.
  task automatic check_near(input longint got, input longint exp);
    compares++;
    if (got > exp + 4 || got < exp - 4) begin
      failures++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Xorshift source of configuration words.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  // One-cycle register read; the data stand in the following cycle.
  task automatic rd(input logic [7:0] a);
    @(posedge clk) reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk) reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  // Waits for one feedback tick to be taken by the block.
  task automatic wait_tick();
    int i;
    for (i = 0; i < 50 && feedback_tick !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 50) begin
      failures++;
      conclude();
    end
    @(posedge clk);
    #1;
  endtask
  // Sums the divider ratio over n ticks against the average the ratio asks for.
  task automatic measure(input int n, input longint ex);
    acc = 0;
    repeat (n) begin
      wait_tick();
      acc += divider_ratio_ff;
    end
    check_near(acc, ex);
  endtask
  // Reset, then bring the regulators up and follow the startup sequence.
  task automatic boot(input logic err);
    int i;
    @(posedge clk) reset_n <= 1'b0;
    regulators_ok <= 1'b0;
    cal_err_mode <= err;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk);
    #1 check({29'h0, block_reset_n_ff, pll_reset_n_ff, bias_cal_start}, 32'h0);
    check({31'h0, ref_input_enable}, 32'h0);
    @(posedge clk) regulators_ok <= 1'b1;
    for (i = 0; i < 300 && block_reset_n_ff !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check({31'h0, pll_reset_n_ff}, 32'h0);
    for (i = 0; i < 300 && pll_reset_n_ff !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 300) begin
      failures++;
      conclude();
    end
    check({31'h0, pll_reset_n_ff}, 32'h1);
    repeat (3) @(posedge clk);
    rd(ADDR_STATUS);
    check(rd_v & 32'h3f, {27'h0, 3'b100, err, ~err});
  endtask
  initial begin
    boot(1'b0);
    boot(1'b1);
    rd(ADDR_FBINT);
    check(rd_v, FBINT_RST);
    rd(ADDR_REFCFG);
    check(rd_v, REFCFG_RST);
    rd(8'h3c);
    check(rd_v, 32'h0);
    // Random words on the loose configuration bits; range follows its register field.
    repeat (8) begin
      seed = xs(seed);
      wr(ADDR_REFCFG, seed & 32'h37);
      wr(ADDR_PLLCFG, seed & 32'h3);
      @(posedge clk);
      #1 check({26'h0, lock_range_sel, 1'b0, ref_input_enable, ac_coupled_bias_enable,
        ref_cmos_select}, seed & 32'h37);
      check({30'h0, ref_from_clkin, doubler_enable}, seed & 32'h3);
    end
    // Lock shows on status and pin; a drop leaves a sticky event cleared by a one.
    wr(ADDR_PLLCFG, 32'h8);
    lock_on <= 1'b1;
    repeat (4) @(posedge clk);
    #1 check({31'h0, gpo_lock}, 32'h1);
    rd(ADDR_STATUS);
    check(rd_v & 32'hc, 32'h4);
    @(posedge clk) lock_on <= 1'b0;
    repeat (3) @(posedge clk);
    lock_on <= 1'b1;
    repeat (3) @(posedge clk);
    wr(ADDR_STATUS, 32'h0);
    rd(ADDR_STATUS);
    check(rd_v & 32'hc, 32'hc);
    wr(ADDR_STATUS, 32'h8);
    rd(ADDR_STATUS);
    check(rd_v & 32'hc, 32'h4);
    // Bypass with an integer ratio; the new ratio waits for apply and a tick.
    wr(ADDR_PLLCFG, 32'h4);
    @(posedge clk);
    #1 check({31'h0, third_pole_bypass}, 32'h1);
    tick_en <= 1'b0;
    wr(ADDR_FBINT, 32'h50);
    wr(ADDR_FBFRAC, 32'h0180_0000);
    wr(ADDR_APPLY, 32'h1);
    rd(ADDR_STATUS);
    check(rd_v & 32'h20, 32'h20);
    rd(ADDR_FBINT);
    check(rd_v, FBINT_RST);
    tick_en <= 1'b1;
    wait_tick();
    rd(ADDR_STATUS);
    check(rd_v & 32'h20, 32'h0);
    rd(ADDR_FBFRAC);
    check(rd_v, 32'h0180_0000);
    check({31'h0, third_pole_bypass}, 32'h0);
    measure(64, 64 * 80 + 12);
    // Offset word of full positive scale, in DCO mode and then as trim.
    wr(ADDR_MODE, 32'h1);
    wr(ADDR_FREQ, 32'h7fff_ffff);
    wait_tick();
    measure(512, 512 * 80 + 96 + ((longint'(41056) * 64'h7fff_ffff) >>> 40));
    wr(ADDR_MODE, 32'h0);
    wr(ADDR_TRIM, 32'h7fff_ffff);
    wr(ADDR_APPLY, 32'h1);
    wait_tick();
    measure(512, 512 * 80 + 96 + ((longint'(41056) * 64'h7fff_ffff) >>> 40));
    wr(ADDR_MODE, 32'h1);
    wr(ADDR_FREQ, 32'h8000_0001);
    wait_tick();
    measure(512, 512 * 80 + 96);
    // Clock generator mode needs the differential input running.
    wr(ADDR_REFCFG, 32'h0);
    wr(ADDR_MODE, 32'h2);
    @(posedge clk);
    #1 check({30'h0, ref_input_enable, ref_from_clkin}, 32'h3);
    // An undefined mode code falls back to the synthesizer.
    wr(ADDR_MODE, 32'h3);
    rd(ADDR_MODE);
    check(rd_v, 32'h0);
    check({31'h0, ref_from_clkin}, 32'h0);
    conclude();
  end
endmodule // fractional_pll_dco_control_test
